// File: include/otgev_pkg.sv
// constants and carrier types for the on-the-go control and event register block
// assumes a single clock domain; pin level inputs are raw and get synchronised inside
package otgev_pkg;

  // ----------------------------------------------------------------
  // register addresses (6-bit command address field)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_OTG    = 6'h0a;
  localparam logic [5:0] ADDR_RISE   = 6'h0d;
  localparam logic [5:0] ADDR_FALL   = 6'h10;
  localparam logic [5:0] ADDR_STATUS = 6'h13;
  localparam logic [5:0] ADDR_LATCH  = 6'h14;
  localparam logic [5:0] OFS_SET     = 6'h01;
  localparam logic [5:0] OFS_CLR     = 6'h02;

  // ----------------------------------------------------------------
  // command byte encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ  = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OTG_RESET    = 8'h06;
  localparam logic [4:0] RISE_RESET   = 5'h1f;
  localparam logic [4:0] FALL_RESET   = 5'h1f;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] LATCH_RESET  = 5'h00;
  localparam logic [2:0] RSVD_ZERO    = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OTG_ID_PULLUP   = 0;
  localparam int OTG_DP_PULLDOWN = 1;
  localparam int OTG_DM_PULLDOWN = 2;
  localparam int OTG_DISCHARGE   = 3;
  localparam int OTG_CHARGE      = 4;
  localparam int OTG_DRIVE_INT   = 5;
  localparam int OTG_DRIVE_EXT   = 6;
  localparam int OTG_USE_EXT     = 7;

  localparam int SRC_N           = 5;
  localparam int SRC_HOST_DETACH = 0;
  localparam int SRC_POWER_VALID = 1;
  localparam int SRC_SESS_VALID  = 2;
  localparam int SRC_SESS_END    = 3;
  localparam int SRC_ID_GND      = 4;

  localparam int SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OTGEV_OP_NONE,
    OTGEV_OP_WRITE,
    OTGEV_OP_SET,
    OTGEV_OP_CLEAR
  } otgev_op_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } otgev_cmd_t;

  typedef struct packed {
    logic id_pin_pullup_en;
    logic plus_line_pulldown_en;
    logic minus_line_pulldown_en;
    logic bus_power_discharge_en;
    logic bus_power_charge_en;
    logic vbus_supply_request;
    logic use_ext_power_indicator;
  } otgev_pins_t;

  typedef struct packed {
    logic host_detach;
    logic power_valid_int;
    logic ext_power_indicator_in;
    logic session_valid_flag;
    logic session_end_flag;
    logic id_grounded_flag;
  } otgev_sense_t;

endpackage : otgev_pkg

// File: hw/otgev_sync.sv
// multi-bit level synchroniser for the comparator and indicator pins
// assumes each bit is an independent slow level; no word coherence is implied
`timescale 1ns/1ns
module otgev_sync #(
  parameter int W      = 6,
  parameter int STAGES = otgev_pkg::SYNC_STAGES
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  logic [W-1:0] stage_reg  [STAGES];
  logic [W-1:0] stage_next [STAGES];

  // each stage is read only by the next stage, except the last one, which drives q
  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      stage_next[i] = stage_reg[i];
    end
    if (ce) begin
      stage_next[0] = d;
      for (int i = 1; i < STAGES; i++) begin
        stage_next[i] = stage_reg[i-1];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= stage_next[i];
      end
    end
  end

  assign q = stage_reg[STAGES-1];

endmodule : otgev_sync

// File: hw/otgev_regs.sv
// on-the-go control register and line/session event registers
// assumes the command byte framing has been stripped upstream and arrives as
// one valid cycle on mclk carrying command and write data together
`timescale 1ns/1ns
module otgev_regs (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   host_mode,
  input  wire otgev_pkg::otgev_sense_t sense,
  input  wire otgev_pkg::otgev_cmd_t   cmd,
  output logic                        rdata_valid,
  output logic [7:0]                  rdata,
  output otgev_pkg::otgev_pins_t      pins,
  output logic                        rx_status_req,
  output logic [3:0]                  comparator_state
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic otgev_pkg::otgev_op_t reg_op(input logic [5:0] a,
                                                  input logic [5:0] base);
    if (a == base) begin
      reg_op = otgev_pkg::OTGEV_OP_WRITE;
    end else if (a == base + otgev_pkg::OFS_SET) begin
      reg_op = otgev_pkg::OTGEV_OP_SET;
    end else if (a == base + otgev_pkg::OFS_CLR) begin
      reg_op = otgev_pkg::OTGEV_OP_CLEAR;
    end else begin
      reg_op = otgev_pkg::OTGEV_OP_NONE;
    end
  endfunction : reg_op

  function automatic logic [7:0] apply_op(input otgev_pkg::otgev_op_t op,
                                          input logic [7:0] cur,
                                          input logic [7:0] wd);
    case (op)
      otgev_pkg::OTGEV_OP_WRITE: apply_op = wd;
      otgev_pkg::OTGEV_OP_SET:   apply_op = cur | wd;
      otgev_pkg::OTGEV_OP_CLEAR: apply_op = cur & ~wd;
      default:                   apply_op = cur;
    endcase
  endfunction : apply_op

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  otgev_pkg::otgev_sense_t sense_sync;

  otgev_sync #(
    .W      ($bits(otgev_pkg::otgev_sense_t)),
    .STAGES (otgev_pkg::SYNC_STAGES)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    (sense),
    .q    (sense_sync)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]             otg_reg;
  logic [7:0]             otg_next;
  logic [4:0]             rise_en_reg;
  logic [4:0]             rise_en_next;
  logic [4:0]             fall_en_reg;
  logic [4:0]             fall_en_next;
  logic [4:0]             status_reg;
  logic [4:0]             status_next;
  logic [4:0]             latch_reg;
  logic [4:0]             latch_next;
  otgev_pkg::otgev_pins_t pins_reg;
  otgev_pkg::otgev_pins_t pins_next;

  // pin levels at reset follow the control reset value, so both pull-downs start on
  localparam otgev_pkg::otgev_pins_t PINS_RESET = '{
    id_pin_pullup_en:        otgev_pkg::OTG_RESET[otgev_pkg::OTG_ID_PULLUP],
    plus_line_pulldown_en:   otgev_pkg::OTG_RESET[otgev_pkg::OTG_DP_PULLDOWN],
    minus_line_pulldown_en:  otgev_pkg::OTG_RESET[otgev_pkg::OTG_DM_PULLDOWN],
    bus_power_discharge_en:  otgev_pkg::OTG_RESET[otgev_pkg::OTG_DISCHARGE],
    bus_power_charge_en:     otgev_pkg::OTG_RESET[otgev_pkg::OTG_CHARGE],
    vbus_supply_request:     otgev_pkg::OTG_RESET[otgev_pkg::OTG_DRIVE_INT] |
                             otgev_pkg::OTG_RESET[otgev_pkg::OTG_DRIVE_EXT],
    use_ext_power_indicator: otgev_pkg::OTG_RESET[otgev_pkg::OTG_USE_EXT]};
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;
  logic                   rdata_valid_reg;
  logic                   rdata_valid_next;
  logic                   rx_req_reg;
  logic                   rx_req_next;
  logic [3:0]             comp_reg;
  logic [3:0]             comp_next;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic                  taken;
  logic                  is_write;
  logic                  is_read;
  logic [5:0]            addr;
  otgev_pkg::otgev_op_t  otg_op;
  otgev_pkg::otgev_op_t  rise_op;
  otgev_pkg::otgev_op_t  fall_op;
  logic                  latch_read;

  assign taken      = ce & cmd.valid;
  assign addr       = cmd.cmd[5:0];
  assign is_write   = taken && (cmd.cmd[7:6] == otgev_pkg::CMD_WRITE);
  assign is_read    = taken && (cmd.cmd[7:6] == otgev_pkg::CMD_READ);
  assign otg_op     = is_write ? reg_op(addr, otgev_pkg::ADDR_OTG)  : otgev_pkg::OTGEV_OP_NONE;
  assign rise_op    = is_write ? reg_op(addr, otgev_pkg::ADDR_RISE) : otgev_pkg::OTGEV_OP_NONE;
  assign fall_op    = is_write ? reg_op(addr, otgev_pkg::ADDR_FALL) : otgev_pkg::OTGEV_OP_NONE;
  assign latch_read = is_read && (addr == otgev_pkg::ADDR_LATCH);

  // ----------------------------------------------------------------
  // sources and edges
  // ----------------------------------------------------------------
  logic [4:0] src;
  logic [4:0] rise_vec;
  logic [4:0] fall_vec;
  logic [4:0] ev_rise;
  logic [4:0] ev_fall;
  logic [4:0] ev;
  logic [4:0] host_gate;

  // detach is forced low outside host mode so it can neither show nor latch
  assign src[otgev_pkg::SRC_HOST_DETACH] = sense_sync.host_detach & host_mode;
  assign src[otgev_pkg::SRC_POWER_VALID] = otg_reg[otgev_pkg::OTG_USE_EXT] ?
                                           sense_sync.ext_power_indicator_in :
                                           sense_sync.power_valid_int;
  assign src[otgev_pkg::SRC_SESS_VALID]  = sense_sync.session_valid_flag;
  assign src[otgev_pkg::SRC_SESS_END]    = sense_sync.session_end_flag;
  assign src[otgev_pkg::SRC_ID_GND]      = sense_sync.id_grounded_flag;

  // status_reg doubles as the previous sample, so each change is seen once
  assign rise_vec  = src & ~status_reg;
  assign fall_vec  = ~src & status_reg;
  assign ev_rise   = rise_vec & rise_en_reg;
  assign ev_fall   = fall_vec & fall_en_reg;
  assign host_gate = {4'hf, host_mode};
  assign ev        = (ev_rise | ev_fall) & host_gate;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    otg_next         = otg_reg;
    rise_en_next     = rise_en_reg;
    fall_en_next     = fall_en_reg;
    status_next      = status_reg;
    latch_next       = latch_reg;
    rdata_next       = rdata_reg;
    rdata_valid_next = rdata_valid_reg;
    rx_req_next      = rx_req_reg;
    comp_next        = comp_reg;
    if (ce) begin
      otg_next     = apply_op(otg_op, otg_reg, cmd.wdata);
      rise_en_next = 5'(apply_op(rise_op, {3'h0, rise_en_reg}, cmd.wdata));
      fall_en_next = 5'(apply_op(fall_op, {3'h0, fall_en_reg}, cmd.wdata));
      status_next  = src;
      // a new event beats the read clear in the same cycle
      latch_next   = (latch_read ? otgev_pkg::LATCH_RESET : latch_reg) | ev;
      rx_req_next  = |(rise_vec[4:1] | fall_vec[4:1]);
      comp_next    = src[4:1];
      rdata_valid_next = is_read;
      if (is_read) begin
        if (reg_op(addr, otgev_pkg::ADDR_OTG) != otgev_pkg::OTGEV_OP_NONE) begin
          rdata_next = otg_reg;
        end else if (reg_op(addr, otgev_pkg::ADDR_RISE) != otgev_pkg::OTGEV_OP_NONE) begin
          rdata_next = {otgev_pkg::RSVD_ZERO, rise_en_reg};
        end else if (reg_op(addr, otgev_pkg::ADDR_FALL) != otgev_pkg::OTGEV_OP_NONE) begin
          rdata_next = {otgev_pkg::RSVD_ZERO, fall_en_reg};
        end else if (addr == otgev_pkg::ADDR_STATUS) begin
          rdata_next = {otgev_pkg::RSVD_ZERO, status_reg};
        end else if (addr == otgev_pkg::ADDR_LATCH) begin
          rdata_next = {otgev_pkg::RSVD_ZERO, latch_reg};
        end else begin
          rdata_next = 8'h00;
        end
      end
    end
  end

  always_comb begin
    pins_next.id_pin_pullup_en        = otg_next[otgev_pkg::OTG_ID_PULLUP];
    pins_next.plus_line_pulldown_en   = otg_next[otgev_pkg::OTG_DP_PULLDOWN];
    pins_next.minus_line_pulldown_en  = otg_next[otgev_pkg::OTG_DM_PULLDOWN];
    pins_next.bus_power_discharge_en  = otg_next[otgev_pkg::OTG_DISCHARGE];
    pins_next.bus_power_charge_en     = otg_next[otgev_pkg::OTG_CHARGE];
    pins_next.vbus_supply_request     = otg_next[otgev_pkg::OTG_DRIVE_INT] |
                                        otg_next[otgev_pkg::OTG_DRIVE_EXT];
    pins_next.use_ext_power_indicator = otg_next[otgev_pkg::OTG_USE_EXT];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      otg_reg         <= otgev_pkg::OTG_RESET;
      rise_en_reg     <= otgev_pkg::RISE_RESET;
      fall_en_reg     <= otgev_pkg::FALL_RESET;
      status_reg      <= otgev_pkg::STATUS_RESET;
      latch_reg       <= otgev_pkg::LATCH_RESET;
      pins_reg        <= PINS_RESET;
      rdata_reg       <= 8'h00;
      rdata_valid_reg <= 1'b0;
      rx_req_reg      <= 1'b0;
      comp_reg        <= 4'h0;
    end else begin
      otg_reg         <= otg_next;
      rise_en_reg     <= rise_en_next;
      fall_en_reg     <= fall_en_next;
      status_reg      <= status_next;
      latch_reg       <= latch_next;
      pins_reg        <= pins_next;
      rdata_reg       <= rdata_next;
      rdata_valid_reg <= rdata_valid_next;
      rx_req_reg      <= rx_req_next;
      comp_reg        <= comp_next;
    end
  end

  // pulses stretch while ce is low since all state freezes
  assign rdata_valid      = rdata_valid_reg;
  assign rdata            = rdata_reg;
  assign pins             = pins_reg;
  assign rx_status_req    = rx_req_reg;
  assign comparator_state = comp_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] otg_set_val;
  logic       otg_set_hit;
  logic       otg_wr_hit;
  assign otg_set_val = otg_reg | cmd.wdata;
  assign otg_set_hit = (otg_op == otgev_pkg::OTGEV_OP_SET);
  assign otg_wr_hit  = (otg_op == otgev_pkg::OTGEV_OP_WRITE);

  property p_id_pullup;
    otg_wr_hit |=> pins.id_pin_pullup_en == $past(cmd.wdata[0]);
  endproperty
  a_id_pullup: assert property (p_id_pullup) else $error("id pull-up wrong");

  property p_pulldowns;
    otg_wr_hit |=> pins.plus_line_pulldown_en == $past(cmd.wdata[1]) &&
                   pins.minus_line_pulldown_en == $past(cmd.wdata[2]);
  endproperty
  a_pulldowns: assert property (p_pulldowns) else $error("pull-down wrong");

  property p_charge;
    otg_wr_hit |=> pins.bus_power_discharge_en == $past(cmd.wdata[3]) &&
                   pins.bus_power_charge_en == $past(cmd.wdata[4]);
  endproperty
  a_charge: assert property (p_charge) else $error("charge control wrong");

  property p_supply_or;
    pins.vbus_supply_request == (otg_reg[5] | otg_reg[6]);
  endproperty
  a_supply_or: assert property (p_supply_or) else $error("supply request wrong");

  property p_set_only;
    otg_set_hit |=> otg_reg == $past(otg_set_val);
  endproperty
  a_set_only: assert property (p_set_only) else $error("set access wrong");

  property p_rise_latch;
    ce && (ev_rise[4:1] != 4'h0) |=> (latch_reg[4:1] & $past(ev_rise[4:1])) ==
                                     $past(ev_rise[4:1]);
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("rise not latched");

  property p_fall_latch;
    ce && (ev_fall[4:1] != 4'h0) |=> (latch_reg[4:1] & $past(ev_fall[4:1])) ==
                                     $past(ev_fall[4:1]);
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("fall not latched");

  property p_detach_host;
    ce && !host_mode |=> !status_reg[0];
  endproperty
  a_detach_host: assert property (p_detach_host) else $error("detach outside host");

  property p_latch_clear;
    latch_read && (ev == 5'h00) |=> latch_reg == 5'h00 ##0 rdata[7:5] == 3'h0;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_edge_once;
    ce && (rise_vec != 5'h00) |=> !ce || ((rise_vec & $past(rise_vec)) == 5'h00);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

  property p_rx_req;
    ce && ((rise_vec[4:1] | fall_vec[4:1]) != 4'h0) |=> rx_status_req;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("status byte not requested");

  property p_clr_read;
    is_read && (addr == otgev_pkg::ADDR_OTG + otgev_pkg::OFS_CLR) |=>
      rdata_valid && rdata == $past(otg_reg);
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("control read wrong");

  c_otg_write:  cover property (otg_wr_hit ##1 pins.vbus_supply_request);
  c_rise_event: cover property (ce && ev_rise != 5'h00);
  c_latch_read: cover property (latch_read && latch_reg != 5'h00);
  c_rx_req:     cover property (rx_status_req);

endmodule : otgev_regs

// File: tb/otgev_link_model.sv
// link controller model: issues one register command per call on the command carrier
// assumes a read answer shows by the falling edge right after the edge that takes the command
`timescale 1ns/1ns
module otgev_link_model (
  input  wire logic             mclk,
  output otgev_pkg::otgev_cmd_t cmd,
  input  wire logic             rdata_valid,
  input  wire logic [7:0]       rdata
);
  initial cmd = '0;
  // ----------------------------------------------------------------
  // one command, driven off the falling edge and held over one rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic [1:0] op, input logic [5:0] a, input logic [7:0] wd,
                      output logic ok, output logic [7:0] rd);
    @(negedge mclk);
    cmd <= '{valid: 1'b1, cmd: {op, a}, wdata: wd};
    @(posedge mclk);
    @(negedge mclk);
    ok = rdata_valid;
    rd = rdata;
    // released fields flip so a stale command can never look valid by accident
    cmd <= '{valid: 1'b0, cmd: ~{op, a}, wdata: ~wd};
  endtask : xfer
endmodule : otgev_link_model

// File: tb/otgev_regs_tb_top.sv
// self-checking bench for the control and event register block
// assumes the link model drives commands; bench drives sense, ce and host_mode
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module otgev_regs_tb_top;
  logic                     mclk = 1'b0;
  logic                     rst = 1'b1;
  logic                     ce = 1'b1;
  logic                     host_mode = 1'b0;
  otgev_pkg::otgev_sense_t  sense = '0;
  otgev_pkg::otgev_cmd_t    cmd;
  otgev_pkg::otgev_pins_t   pins;
  logic                     rdata_valid;
  logic [7:0]               rdata;
  logic                     rx_status_req;
  logic [3:0]               comparator_state;
  int                       failures = 0;
  int                       num_checks = 0;
  logic [7:0]               ctl = 8'h06;
  logic [4:0]               ren = 5'h1f;
  logic [4:0]               fen = 5'h1f;

  always #2 mclk = ~mclk;

  otgev_regs dut_u (.mclk(mclk), .rst(rst), .ce(ce), .host_mode(host_mode), .sense(sense),
    .cmd(cmd), .rdata_valid(rdata_valid), .rdata(rdata), .pins(pins),
    .rx_status_req(rx_status_req), .comparator_state(comparator_state));
  otgev_link_model link_u (.mclk(mclk), .cmd(cmd), .rdata_valid(rdata_valid), .rdata(rdata));

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] pins_of(logic [7:0] c);
    return {c[0], c[1], c[2], c[3], c[4], c[5] | c[6], c[7]};
  endfunction : pins_of
  function automatic logic [4:0] src_of(otgev_pkg::otgev_sense_t s, logic hm, logic ue);
    return {s.id_grounded_flag, s.session_end_flag, s.session_valid_flag,
            ue ? s.ext_power_indicator_in : s.power_valid_int, s.host_detach & hm};
  endfunction : src_of
  function automatic logic [7:0] upd(logic [7:0] cur, int op, logic [7:0] wd);
    if (op == 0) begin
      return wd;
    end else if (op == 1) begin
      return cur | wd;
    end
    return cur & ~wd;
  endfunction : upd
  // status and latch are checked apart; every other address outside the windows reads zero
  function automatic logic [7:0] exp_rd(logic [5:0] a);
    if (a >= 6'h0a && a <= 6'h0c) begin
      return ctl;
    end else if (a >= 6'h0d && a <= 6'h0f) begin
      return {3'h0, ren};
    end else if (a >= 6'h10 && a <= 6'h12) begin
      return {3'h0, fen};
    end
    return 8'h00;
  endfunction : exp_rd

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    logic ok;
    link_u.xfer(otgev_pkg::CMD_READ, a, 8'h00, ok, d);
    `CHK("read answer", 1'b1, ok)
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [7:0] w);
    logic       ok;
    logic [7:0] x;
    link_u.xfer(otgev_pkg::CMD_WRITE, a, w, ok, x);
    `CHK("write answer", 1'b0, ok)
  endtask : wr

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // cut a hang well past the expected run of under a thousand cycles
  initial begin
    #40000;
    failures++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] w;
    logic [5:0] a;
    logic [4:0] p;
    logic [4:0] n;
    logic       rx;
    int         j;
    void'($urandom(59147));
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    `CHK("pins reset", pins_of(otgev_pkg::OTG_RESET), pins)
    for (int k = 8'h0a; k <= 8'h16; k++) begin
      rd(6'(k), d);
      `CHK("reset read", exp_rd(6'(k)), d)
    end
    // random write, set and clear over all nine window addresses
    for (int i = 0; i < 40; i++) begin
      j = $urandom_range(0, 8);
      w = 8'($urandom);
      wr(6'h0a + 6'(j), w);
      if (j / 3 == 0) begin
        ctl = upd(ctl, j % 3, w);
      end else if (j / 3 == 1) begin
        ren = 5'(upd({3'h0, ren}, j % 3, w));
      end else begin
        fen = 5'(upd({3'h0, fen}, j % 3, w));
      end
      `CHK("pins", pins_of(ctl), pins)
      a = 6'h0a + 6'($urandom_range(0, 8));
      rd(a, d);
      `CHK("readback", exp_rd(a), d)
    end
    wr(6'h13, 8'hff);
    rd(6'h13, d);
    `CHK("status write ignored", 8'h00, d)
    @(negedge mclk);
    ce = 1'b0;
    wr(6'h0a, ~ctl);
    ce = 1'b1;
    `CHK("pins frozen", pins_of(ctl), pins)
    // random source changes against random masks and host mode
    for (int i = 0; i < 30; i++) begin
      @(negedge mclk);
      host_mode = 1'($urandom);
      // set or clear the power indicator choice at random; any edge it makes is cleared below
      j = $urandom_range(1, 2);
      wr(6'h0a + 6'(j), 8'h80);
      ctl = upd(ctl, j, 8'h80);
      `CHK("indicator select", pins_of(ctl), pins)
      repeat (5) @(negedge mclk);
      rd(6'h14, d);
      p = src_of(sense, host_mode, ctl[7]);
      sense = 6'($urandom);
      rx = 1'b0;
      repeat (6) begin
        @(negedge mclk);
        rx |= rx_status_req;
      end
      n = src_of(sense, host_mode, ctl[7]);
      `CHK("comparators", n[4:1], comparator_state)
      `CHK("status request", |(p[4:1] ^ n[4:1]), rx)
      rd(6'h13, d);
      `CHK("status", {3'h0, n}, d)
      rd(6'h14, d);
      `CHK("latch", {3'h0, (ren & n & ~p) | (fen & ~n & p)}, d)
      rd(6'h14, d);
      `CHK("latch cleared", 8'h00, d)
    end
    end_sim();
  end
endmodule : otgev_regs_tb_top
